// [core/usb_endpoint_buffers.sv]
// Module: shared endpoint RAM, descriptor table and serial engine
// Operation
// - One shared 256-byte bank for core and engine
// - Bank at core 0x1860 equals engine 0x00
// - Lowest 32 bytes hold descriptor table
// - Entry holds count, buffer offset, data toggle
// - Engine resolves buffers at 16-byte granularity
// - Offset field is base shifted right two
// - Endpoint control sets direction and handshake enable
// - Owned IN buffer sent on token, interrupt after
// - OUT data stored in buffer, interrupt raised
// - Ownership bit arbitrates buffer access
// - Control traffic uses endpoint zero only
// - Control byte: ownership, sync enable, toggle bits
// - Module reset bit restores register defaults, except last endpoint and direction in endpoint status
`default_nettype none
module usb_endpoint_buffers
  import usb_bd_pkg::*;
(
  input  wire logic      mclk_in,     // System clock, 50 MHz
  input  wire logic      reset_in,    // Async reset, active high
  input  wire core_req_t core_in,     // Core register/RAM request
  output logic     [7:0] core_rdata_out, // Read data, cycle after read
  input  wire logic      tok_valid_in, // Token from host, one cycle
  input  wire token_t    tok_in,      // Token kind and endpoint
  input  wire logic      rx_valid_in, // Received data byte strobe
  input  wire logic [7:0] rx_data_in, // Received data byte
  input  wire logic      rx_end_in,   // End of received data packet
  input  wire logic      rx_data1_in, // Received packet was DATA1
  output logic           tx_valid_out, // Transmit byte valid
  output var tx_byte_t   tx_out,      // Transmit byte and flags
  input  wire logic      tx_ready_in, // Link takes transmit byte
  input  wire logic      host_ack_in, // Host acknowledged IN data
  output logic           hs_valid_out, // Handshake strobe
  output var hs_code_t   hs_out,      // Handshake code
  output logic           irq_out      // Level interrupt
);
  logic [7:0]  ram [BANK_SIZE];
  logic [2:0]  ep_ctl [NUM_EP];
  logic        usb_en;
  logic [2:0]  int_stat;
  logic [2:0]  int_mask;
  eng_state_t  state;
  token_t      cur_tok;
  logic [2:0]  cur_bd;
  logic [7:0]  cur_ctl;
  logic [7:0]  cur_base;
  logic [7:0]  mcnt;
  logic [7:0]  xcnt;
  logic        discard;
  logic        rx_data1;
  logic [2:0]  last_ep;
  logic        last_in;

  logic        in_bank;
  logic [15:0] bank_off;
  logic [7:0]  core_idx;
  logic        soft_clr;
  logic        stat_rd;
  logic        take_tok;
  logic [7:0]  bd_base;
  logic [7:0]  bd_ctl;
  logic [7:0]  bd_cnt;
  logic [7:0]  bd_adr;
  logic [2:0]  epc;
  logic        ep_ok;
  logic        own;
  logic        eng_we;
  logic [7:0]  eng_addr;
  logic [7:0]  eng_wdata;
  logic [2:0]  ev;
  logic [7:0]  next_rdata;
  logic        rx_store;
  logic        tx_take;
  logic [7:0]  tx_idx;

  // Core address decode for the shared bank
  assign in_bank  = core_in.addr >= BANK_BASE && core_in.addr < BANK_END;
  assign bank_off = core_in.addr - BANK_BASE;
  assign core_idx = bank_off[7:0];
  assign soft_clr = core_in.wr && core_in.addr == CTL_ADDR && core_in.wdata[UC_RESET_BIT];
  assign stat_rd  = core_in.rd && core_in.addr == INT_STAT_ADDR;

  // Descriptor entry of the current token, four bytes per entry
  assign bd_base = {3'b000, cur_bd, 2'b00};
  assign bd_ctl  = ram[bd_base];
  assign bd_cnt  = ram[bd_base + BD_CNT_OFS];
  assign bd_adr  = ram[bd_base + BD_ADR_OFS];
  assign epc     = ep_ctl[cur_tok.ep];
  assign own     = bd_ctl[BD_OWN_BIT];
  assign ep_ok   = (cur_tok.kind == TOK_IN) ? epc[EPC_TX_BIT]
                 : (epc[EPC_RX_BIT] && (cur_tok.kind != TOK_SETUP || cur_tok.ep == 3'h0));

  assign take_tok = tok_valid_in && usb_en && tok_in.ep < 3'(NUM_EP)
                 && (state == ST_IDLE || state == ST_WAIT_ACK);
  assign rx_store = state == ST_RECV && rx_valid_in && !discard && xcnt < mcnt;
  assign tx_take  = state == ST_SEND && tx_valid_out && tx_ready_in;

  // Engine write port into the shared bank
  always_comb
  begin
    eng_we    = 1'b0;
    eng_addr  = 8'h00;
    eng_wdata = 8'h00;
    case (state)
      ST_RECV:
      begin
        eng_we    = rx_store;
        eng_addr  = cur_base + xcnt;
        eng_wdata = rx_data_in;
      end
      ST_WB_CNT:
      begin
        eng_we    = 1'b1;
        eng_addr  = bd_base + BD_CNT_OFS;
        eng_wdata = xcnt;
      end
      ST_WB_CTL:
      begin
        eng_we    = 1'b1;
        eng_addr  = bd_base;
        eng_wdata = {1'b0, (cur_tok.kind == TOK_IN) ? cur_ctl[BD_DATA1_BIT] : rx_data1,
                     cur_ctl[5:0]};
      end
      default:
      begin
        eng_we = 1'b0;
      end
    endcase
  end

  // Shared RAM: engine wins a same-byte collision
  always_ff @(posedge mclk_in)
  begin
    if (core_in.wr && in_bank && !(eng_we && eng_addr == core_idx))
      ram[core_idx] <= core_in.wdata;
    if (eng_we)
      ram[eng_addr] <= eng_wdata;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_epc
      ep_ctl_reg u_epc (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .clear_in (soft_clr),
        .we_in    (core_in.wr && core_in.addr == EP_CTL_BASE + 16'(g)),
        .wdata_in (core_in.wdata[2:0]),
        .ctl_out  (ep_ctl[g])
      );
    end
  endgenerate

  // Control and mask registers
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      usb_en   <= 1'b0;
      int_mask <= INT_RESET;
    end
    else if (soft_clr)
    begin
      usb_en   <= 1'b0;
      int_mask <= INT_RESET;
    end
    else if (core_in.wr)
    begin
      if (core_in.addr == CTL_ADDR)
        usb_en <= core_in.wdata[UC_EN_BIT];
      if (core_in.addr == INT_MASK_ADDR)
        int_mask <= core_in.wdata[2:0];
    end
  end

  // Sticky status: a new event beats the read clear
  always_comb
  begin
    ev = 3'h0;
    if (state == ST_WB_CTL)
    begin
      ev[INT_TX_BIT]    = cur_tok.kind == TOK_IN;
      ev[INT_RX_BIT]    = cur_tok.kind != TOK_IN;
      ev[INT_SETUP_BIT] = cur_tok.kind == TOK_SETUP;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      int_stat <= INT_RESET;
    else if (soft_clr)
      int_stat <= INT_RESET;
    else
      int_stat <= (stat_rd ? 3'h0 : int_stat) | ev;
  end

  assign irq_out = |(int_stat & int_mask);

  // Read data mux, answered in the following cycle
  always_comb
  begin
    next_rdata = 8'h00;
    if (in_bank)
      next_rdata = ram[core_idx];
    else if (core_in.addr == CTL_ADDR)
      next_rdata = {7'h00, usb_en};
    else if (core_in.addr == INT_STAT_ADDR)
      next_rdata = {5'h00, int_stat};
    else if (core_in.addr == INT_MASK_ADDR)
      next_rdata = {5'h00, int_mask};
    else if (core_in.addr == EP_STAT_ADDR)
      next_rdata = {state != ST_IDLE, 3'h0, last_in, last_ep};
    else if (core_in.addr[15:3] == EP_CTL_BASE[15:3] && core_in.addr[2:0] < 3'(NUM_EP))
      next_rdata = {5'h00, ep_ctl[core_in.addr[2:0]]};
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      core_rdata_out <= 8'h00;
    else
      core_rdata_out <= core_in.rd ? next_rdata : 8'h00;
  end

  // Engine sequencing
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      state <= ST_IDLE;
    else if (soft_clr)
      state <= ST_IDLE;
    else if (take_tok)
      state <= ST_LOOKUP;
    else
      case (state)
        ST_LOOKUP:
          if (!ep_ok)
            state <= ST_IDLE;
          else if (cur_tok.kind == TOK_IN)
            state <= own ? ST_SEND : ST_IDLE;
          else
            state <= ST_RECV;
        ST_SEND:
          if (tx_take && tx_out.last)
            state <= ST_WAIT_ACK;
        ST_WAIT_ACK:
          if (host_ack_in)
            state <= ST_WB_CNT;
        ST_RECV:
          if (rx_end_in)
            state <= (discard || (cur_ctl[BD_DTS_BIT] && rx_data1_in != cur_ctl[BD_DATA1_BIT]))
                   ? ST_IDLE : ST_WB_CNT;
        ST_WB_CNT:
          state <= ST_WB_CTL;
        ST_WB_CTL:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
  end

  // Transaction context
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cur_tok  <= '{kind: TOK_OUT, ep: 3'h0};
      cur_bd   <= 3'h0;
      cur_ctl  <= 8'h00;
      cur_base <= 8'h00;
      mcnt     <= 8'h00;
      xcnt     <= 8'h00;
      discard  <= 1'b0;
      rx_data1 <= 1'b0;
    end
    else if (take_tok)
    begin
      cur_tok <= tok_in;
      if (tok_in.ep == 3'h0)
        cur_bd <= (tok_in.kind == TOK_IN) ? 3'h0 : 3'h1;
      else
        cur_bd <= tok_in.ep + 3'h1;
    end
    else if (state == ST_LOOKUP)
    begin
      cur_ctl  <= bd_ctl;
      cur_base <= {bd_adr[5:2], 4'h0};
      mcnt     <= bd_cnt;
      xcnt     <= (cur_tok.kind == TOK_IN) ? bd_cnt : 8'h00;
      discard  <= !own;
    end
    else if (state == ST_RECV)
    begin
      if (rx_store)
        xcnt <= xcnt + 8'h01;
      if (rx_end_in)
        rx_data1 <= rx_data1_in;
    end
  end

  // Transmit byte register
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tx_valid_out <= 1'b0;
      tx_out       <= '0;
    end
    else if (soft_clr)
      tx_valid_out <= 1'b0;
    else if (state == ST_LOOKUP && ep_ok && own && cur_tok.kind == TOK_IN)
    begin
      tx_valid_out <= 1'b1;
      tx_out.data  <= ram[{bd_adr[5:2], 4'h0}];
      tx_out.last  <= bd_cnt <= 8'h01;
      tx_out.empty <= bd_cnt == 8'h00;
      tx_out.data1 <= bd_ctl[BD_DATA1_BIT];
    end
    else if (tx_take)
    begin
      if (tx_out.last)
        tx_valid_out <= 1'b0;
      else
      begin
        tx_out.data <= ram[cur_base + tx_idx];
        tx_out.last <= tx_idx + 8'h01 == mcnt;
      end
    end
  end

  // Index of the next byte to load into the transmit register
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      tx_idx <= 8'h00;
    else if (state == ST_LOOKUP)
      tx_idx <= 8'h01;
    else if (tx_take)
      tx_idx <= tx_idx + 8'h01;
  end

  // Handshake to the host
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      hs_valid_out <= 1'b0;
      hs_out       <= HS_ACK;
    end
    else
    begin
      hs_valid_out <= 1'b0;
      if (state == ST_LOOKUP && ep_ok && cur_tok.kind == TOK_IN && !own && epc[EPC_HSHK_BIT])
      begin
        hs_valid_out <= 1'b1;
        hs_out       <= HS_NAK;
      end
      else if (state == ST_RECV && rx_end_in && epc[EPC_HSHK_BIT])
      begin
        hs_valid_out <= 1'b1;
        hs_out       <= discard ? HS_NAK : HS_ACK;
      end
    end
  end

  // Last completed endpoint, visible to software
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      last_ep <= 3'h0;
      last_in <= 1'b0;
    end
    else if (state == ST_WB_CTL)
    begin
      last_ep <= cur_tok.ep;
      last_in <= cur_tok.kind == TOK_IN;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  AST_BANK_MAP: assert property (core_in.wr && in_bank && !eng_we ##1 core_in.rd
      && core_in.addr == $past(core_in.addr) |=> core_rdata_out == $past(core_in.wdata, 2))
    else $error("bank byte not read back at core address");
  AST_ALIGN: assert property ($rose(state == ST_SEND) |-> cur_base[3:0] == 4'h0
      && cur_base[7:4] == $past(bd_adr[5:2]))
    else $error("buffer base not 16-byte aligned from offset field");
  AST_NAK: assert property (state == ST_LOOKUP && ep_ok && cur_tok.kind == TOK_IN && !own
      && epc[EPC_HSHK_BIT] |=> hs_valid_out && hs_out == HS_NAK && state == ST_IDLE)
    else $error("unowned IN buffer not answered with NAK");
  AST_IN_DONE: assert property (state == ST_WAIT_ACK && host_ack_in && !take_tok
      |-> ##3 int_stat[INT_TX_BIT])
    else $error("IN completion did not set status");
  AST_OWN_CLR: assert property (state == ST_WB_CTL |=> !ram[$past(bd_base)][BD_OWN_BIT]
      && ram[$past(bd_base) + BD_CNT_OFS] == $past(xcnt))
    else $error("descriptor not returned to firmware");
  AST_SETUP_EP0: assert property (state == ST_LOOKUP && cur_tok.kind == TOK_SETUP
      && cur_tok.ep != 3'h0 |=> state == ST_IDLE ##1 !hs_valid_out)
    else $error("setup accepted on a non-control endpoint");
  AST_SOFT_RST: assert property (soft_clr |=> !usb_en && int_mask == 3'h0
      && int_stat == 3'h0 && ep_ctl[0] == 3'h0)
    else $error("module reset left registers set");
  AST_RX_STORE: assert property (rx_store |=> ram[$past(cur_base) + $past(xcnt)]
      == $past(rx_data_in) && xcnt == $past(xcnt) + 8'h01)
    else $error("received byte not stored in buffer");
  AST_TX_LAST: assert property (tx_take && tx_out.last && !tx_out.empty
      |-> tx_idx == mcnt)
    else $error("last transmit byte not at byte count");
endmodule // usb_endpoint_buffers
`default_nettype wire

// [core/usb_bd_pkg.sv]
// Package: constants and types for the endpoint buffer block
`default_nettype none
package usb_bd_pkg;
  localparam logic [15:0] BANK_BASE     = 16'h1860; // Core address of shared byte 0
  localparam logic [15:0] BANK_END      = 16'h1960; // First core address past the bank
  localparam int          BANK_SIZE     = 256;
  localparam logic [7:0]  BDT_BYTES     = 8'h20;    // Descriptor table size
  localparam int          NUM_EP        = 7;
  localparam logic [15:0] CTL_ADDR      = 16'h1800;
  localparam logic [15:0] INT_STAT_ADDR = 16'h1801;
  localparam logic [15:0] INT_MASK_ADDR = 16'h1802;
  localparam logic [15:0] EP_STAT_ADDR  = 16'h1803;
  localparam logic [15:0] EP_CTL_BASE   = 16'h1810;
  localparam logic [7:0]  BD_CNT_OFS    = 8'h01;
  localparam logic [7:0]  BD_ADR_OFS    = 8'h02;
  localparam int          BD_OWN_BIT    = 7;
  localparam int          BD_DATA1_BIT  = 6;
  localparam int          BD_DTS_BIT    = 3;
  localparam int          EPC_HSHK_BIT  = 0;
  localparam int          EPC_TX_BIT    = 1;
  localparam int          EPC_RX_BIT    = 2;
  localparam int          UC_EN_BIT     = 0;
  localparam int          UC_RESET_BIT  = 7;
  localparam int          INT_TX_BIT    = 0;
  localparam int          INT_RX_BIT    = 1;
  localparam int          INT_SETUP_BIT = 2;
  localparam logic [2:0]  EPC_RESET     = 3'h0;
  localparam logic [2:0]  INT_RESET     = 3'h0;

  typedef enum logic [1:0] {TOK_OUT = 2'b00, TOK_IN = 2'b01, TOK_SETUP = 2'b10} token_kind_t;
  typedef enum logic {HS_ACK = 1'b0, HS_NAK = 1'b1} hs_code_t;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_LOOKUP   = 3'b001,
    ST_SEND     = 3'b010,
    ST_WAIT_ACK = 3'b011,
    ST_RECV     = 3'b100,
    ST_WB_CNT   = 3'b101,
    ST_WB_CTL   = 3'b110
  } eng_state_t;

  typedef struct packed {
    token_kind_t kind;
    logic [2:0]  ep;
  } token_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } core_req_t;

  typedef struct packed {
    logic       empty;
    logic       last;
    logic       data1;
    logic [7:0] data;
  } tx_byte_t;
endpackage
`default_nettype wire

// [core/ep_ctl_reg.sv]
// Module: one endpoint control register
`default_nettype none
module ep_ctl_reg
  import usb_bd_pkg::*;
(
  input  wire logic       mclk_in,  // System clock
  input  wire logic       reset_in, // Async reset, active high
  input  wire logic       clear_in, // Module soft reset
  input  wire logic       we_in,    // Write strobe for this endpoint
  input  wire logic [2:0] wdata_in, // Handshake, to-host, from-host bits
  output logic      [2:0] ctl_out   // Stored control bits
);
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      ctl_out <= EPC_RESET;
    else if (clear_in)
      ctl_out <= EPC_RESET;
    else if (we_in)
      ctl_out <= wdata_in;
  end
endmodule // ep_ctl_reg
`default_nettype wire

// [core/placeholder_check.sv]
// Empty unit: no logic

// [tb/usb_host_model.sv]
// Host controller model: tokens, OUT data packets, IN collection
`default_nettype none
module usb_host_model
  import usb_bd_pkg::*;
(
  input  wire logic      mclk_in,       // System clock
  input  wire logic      tx_valid_in,   // Device byte valid
  input  wire tx_byte_t  tx_in,         // Device byte and flags
  output var logic       tok_valid_out, // Token strobe
  output var token_t     tok_out,       // Token kind and endpoint
  output var logic       rx_valid_out,  // Data byte strobe
  output var logic [7:0] rx_data_out,   // Data byte
  output var logic       rx_end_out,    // End of data packet
  output var logic       rx_data1_out,  // Packet is DATA1
  output var logic       tx_ready_out,  // Takes device byte
  output var logic       host_ack_out   // IN data acknowledged
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got_q[$];

  initial
  begin
    tok_valid_out = 1'b0;
    tok_out = '0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_end_out = 1'b0;
    rx_data1_out = 1'b0;
    tx_ready_out = 1'b0;
    host_ack_out = 1'b0;
  end

  task automatic token(input token_kind_t k, input logic [2:0] ep);
    @(posedge mclk_in);
    tok_valid_out <= 1'b1;
    tok_out <= '{kind: k, ep: ep};
    @(posedge mclk_in);
    tok_valid_out <= 1'b0;
    tok_out <= '{kind: k, ep: ~ep};
  endtask

  // Bytes go out low byte first, at least two cycles after the token
  task automatic send_out(input logic [31:0] d, input int n, input logic pid);
    @(posedge mclk_in);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk_in);
      rx_valid_out <= 1'b1;
      rx_data_out <= d[8*i+:8];
    end
    @(posedge mclk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
    rx_end_out <= 1'b1;
    rx_data1_out <= pid;
    @(posedge mclk_in);
    rx_end_out <= 1'b0;
    rx_data1_out <= ~pid;
  endtask

  // Slow mode takes a byte only every other cycle
  task automatic take_in(input logic slow, output int n);
    int guard;
    got_q.delete();
    guard = 0;
    while (guard < 60)
    begin
      @(posedge mclk_in);
      tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
      @(negedge mclk_in);
      guard++;
      if (tx_valid_in && tx_ready_out)
      begin
        if (!tx_in.empty)
          got_q.push_back(tx_in.data);
        if (tx_in.last)
          guard = 99;
      end
    end
    @(posedge mclk_in);
    tx_ready_out <= 1'b0;
    host_ack_out <= 1'b1;
    @(posedge mclk_in);
    host_ack_out <= 1'b0;
    n = got_q.size();
  endtask
endmodule // usb_host_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the endpoint buffer block
`default_nettype none
module testbench
  import usb_bd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk, reset, irq;
  core_req_t  core;
  logic [7:0] rdata, rx_data;
  logic       tok_valid, rx_valid, rx_end, rx_data1;
  logic       tx_valid, tx_ready, host_ack, hs_valid;
  token_t     tok;
  tx_byte_t   tx;
  hs_code_t   hs;
  int         bad_count, total_checks;

  usb_endpoint_buffers dut_u (.mclk_in(mclk), .reset_in(reset), .core_in(core),
    .core_rdata_out(rdata), .tok_valid_in(tok_valid), .tok_in(tok),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_end_in(rx_end),
    .rx_data1_in(rx_data1), .tx_valid_out(tx_valid), .tx_out(tx),
    .tx_ready_in(tx_ready), .host_ack_in(host_ack), .hs_valid_out(hs_valid),
    .hs_out(hs), .irq_out(irq));

  usb_host_model host_u (.mclk_in(mclk), .tx_valid_in(tx_valid), .tx_in(tx),
    .tok_valid_out(tok_valid), .tok_out(tok), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .rx_end_out(rx_end), .rx_data1_out(rx_data1),
    .tx_ready_out(tx_ready), .host_ack_out(host_ack));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    core <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    core.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    core <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    core.rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  task automatic hs_expect(input logic seen, input hs_code_t c);
    logic got;
    got = 1'b0;
    repeat (12)
    begin
      @(negedge mclk);
      if (hs_valid === 1'b1 && !got)
      begin
        got = 1'b1;
        check({7'h0, hs}, {7'h0, c});
      end
    end
    check({7'h0, got}, {7'h0, seen});
  endtask

  initial
  begin
    #100us;
    bad_count++;
    close_out();
  end

  initial
  begin
    int n;
    logic [7:0] v;
    logic [31:0] pat;
    bad_count = 0;
    total_checks = 0;
    reset = 1'b1;
    core = '0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    chk_rd(CTL_ADDR, 8'h00);
    chk_rd(INT_MASK_ADDR, 8'h00);
    chk_rd(EP_CTL_BASE, 8'h00);
    check({7'h0, irq}, 8'h00);
    // Both ends of the bank, and the first byte past it
    wr(BANK_BASE, 8'h5A);
    wr(BANK_END - 16'h1, 8'hC3);
    wr(BANK_END, 8'h77);
    chk_rd(BANK_BASE, 8'h5A);
    chk_rd(BANK_END - 16'h1, 8'hC3);
    chk_rd(BANK_END, 8'h00);
    // IN on endpoint 1; offset low bits must be ignored
    wr(CTL_ADDR, 8'h01);
    wr(INT_MASK_ADDR, 8'h03);
    wr(EP_CTL_BASE + 16'h1, 8'h03);
    pat = 32'h00332211;
    for (int i = 0; i < 3; i++)
      wr(16'h18A0 + 16'(i), pat[8*i+:8]);
    wr(BANK_BASE + 16'h9, 8'h03);
    wr(BANK_BASE + 16'hA, 8'h13);
    wr(BANK_BASE + 16'h8, 8'h80);
    host_u.token(TOK_IN, 3'd1);
    host_u.take_in(1'b1, n);
    check(n[7:0], 8'h03);
    for (int i = 0; i < 3; i++)
      check(host_u.got_q[i], pat[8*i+:8]);
    repeat (20)
    begin
      @(negedge mclk);
      if (irq === 1'b1)
        break;
    end
    check({7'h0, irq}, 8'h01);
    chk_rd(EP_STAT_ADDR, 8'h09);
    chk_rd(INT_STAT_ADDR, 8'h01);
    check({7'h0, irq}, 8'h00);
    chk_rd(BANK_BASE + 16'h8, 8'h00);
    chk_rd(BANK_BASE + 16'h9, 8'h03);
    host_u.token(TOK_IN, 3'd1);
    hs_expect(1'b1, HS_NAK);
    // OUT to an endpoint set for IN only is ignored
    host_u.token(TOK_OUT, 3'd1);
    host_u.send_out(32'h000000AB, 1, 1'b0);
    hs_expect(1'b0, HS_ACK);
    // OUT on endpoint 0 with its interrupt masked
    wr(INT_MASK_ADDR, 8'h01);
    wr(EP_CTL_BASE, 8'h07);
    wr(BANK_BASE + 16'h5, 8'h08);
    wr(BANK_BASE + 16'h6, 8'h0C);
    wr(BANK_BASE + 16'h4, 8'h88);
    pat = 32'h00C3B2A1;
    host_u.token(TOK_OUT, 3'd0);
    host_u.send_out(pat, 3, 1'b0);
    hs_expect(1'b1, HS_ACK);
    check({7'h0, irq}, 8'h00);
    chk_rd(INT_STAT_ADDR, 8'h02);
    for (int i = 0; i < 3; i++)
      chk_rd(16'h1890 + 16'(i), pat[8*i+:8]);
    chk_rd(BANK_BASE + 16'h5, 8'h03);
    rd(BANK_BASE + 16'h4, v);
    check(v & 8'hC0, 8'h00);
    // Wrong toggle: acknowledged and stored, but descriptor not returned
    wr(BANK_BASE + 16'h4, 8'h88);
    host_u.token(TOK_OUT, 3'd0);
    host_u.send_out(32'h00000055, 1, 1'b1);
    hs_expect(1'b1, HS_ACK);
    chk_rd(INT_STAT_ADDR, 8'h00);
    chk_rd(16'h1890, 8'h55);
    chk_rd(BANK_BASE + 16'h5, 8'h03);
    rd(BANK_BASE + 16'h4, v);
    check(v & 8'h80, 8'h80);
    // SETUP on the control endpoint
    host_u.token(TOK_SETUP, 3'd0);
    host_u.send_out(32'h00000680, 2, 1'b0);
    hs_expect(1'b1, HS_ACK);
    chk_rd(INT_STAT_ADDR, 8'h06);
    chk_rd(16'h1891, 8'h06);
    // SETUP on a non-control endpoint is ignored
    wr(EP_CTL_BASE + 16'h1, 8'h07);
    host_u.token(TOK_SETUP, 3'd1);
    host_u.send_out(32'h00000011, 1, 1'b0);
    hs_expect(1'b0, HS_ACK);
    chk_rd(INT_STAT_ADDR, 8'h00);
    // Module reset clears registers and leaves the bank alone
    wr(CTL_ADDR, 8'h80);
    chk_rd(CTL_ADDR, 8'h00);
    chk_rd(INT_MASK_ADDR, 8'h00);
    chk_rd(EP_CTL_BASE + 16'h1, 8'h00);
    chk_rd(16'h18A0, 8'h11);
    close_out();
  end
endmodule // testbench
`default_nettype wire
